//--- logic/tcc_channel.sv
// one comparator channel: polarity, edge detect, event latch, request pulse
`timescale 1ns/1ps
`default_nettype none
module tcc_channel (
  input wire logic clock,
  input wire logic reset,
  input wire tcc_pkg::tcc_cfg_t cfg,
  input wire logic run,
  input wire logic raw_sync,
  input wire logic evt_clear,
  output logic result,
  output logic event_latch,
  output logic irq_pulse
);
  import tcc_pkg::*;
  typedef struct packed {
    logic res;
    logic evt;
    logic irq;
  } tcc_chan_t;
  tcc_chan_t st_ff;
  tcc_chan_t nxt_st;
  logic cur;
  logic hit;
  always_comb begin
    // R3: polarity applied
    cur = raw_sync ^ cfg.inv;
    hit = 1'b0;
    // R5: edge choice
    case (cfg.edge_sel)
      EDGE_ANY: hit = cur != st_ff.res;
      EDGE_FALL: hit = st_ff.res & ~cur;
      EDGE_RISE: hit = ~st_ff.res & cur;
      EDGE_OFF: hit = 1'b0;
      default: hit = 1'b0;
    endcase
    nxt_st = st_ff;
    // R1: only when enabled and not idle-stopped
    if (run) begin
      nxt_st.res = cur;
    end else begin
      hit = 1'b0;
      nxt_st.res = 1'b0;
    end
    // R4: latch blocks retrigger; set wins over clear
    nxt_st.evt = (st_ff.evt & ~evt_clear) | hit;
    // R14: one request per arm
    nxt_st.irq = hit & ~st_ff.evt;
  end
  always_ff @(posedge clock) begin
    if (reset) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign result = st_ff.res;
  assign event_latch = st_ff.evt;
  assign irq_pulse = st_ff.irq;
endmodule // tcc_channel
`default_nettype wire

//--- logic/tcc_pkg.sv
// package: register map, field positions and types for the comparator block
package tcc_pkg;
  localparam int unsigned NUM_CMP = 3;
  localparam logic [31:0] RST_VALUE = 32'h0;
  // register byte addresses
  localparam logic [7:0] ADDR_CTRL0 = 8'h00;
  localparam logic [7:0] ADDR_CTRL1 = 8'h04;
  localparam logic [7:0] ADDR_CTRL2 = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_REFCTL = 8'h10;
  localparam logic [7:0] ADDR_MODE = 8'h14;
  // comparator control fields
  localparam int unsigned POS_ON = 15;
  localparam int unsigned POS_OE = 14;
  localparam int unsigned POS_INV = 13;
  localparam int unsigned POS_EVT = 9;
  localparam int unsigned POS_RES = 8;
  localparam int unsigned POS_EDGE = 6;
  localparam int unsigned POS_NISEL = 4;
  localparam int unsigned POS_ISEL = 0;
  localparam logic [15:0] CTRL_WMASK = 16'he2d3;
  // status fields
  localparam int unsigned POS_IDLE_STOP = 15;
  localparam int unsigned POS_STAT_EVT = 8;
  localparam int unsigned POS_STAT_RES = 0;
  // reference control fields
  localparam int unsigned POS_SUPPLY = 5;
  localparam int unsigned POS_LEVEL = 0;
  localparam logic [15:0] REF_WMASK = 16'h07ff;
  // edge selection codes
  localparam logic [1:0] EDGE_OFF = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_ANY = 2'h3;
  // negative input selection codes
  localparam logic [1:0] NEG_PIN_B = 2'h0;
  localparam logic [1:0] NEG_PIN_C = 2'h1;
  localparam logic [1:0] NEG_PIN_D = 2'h2;
  localparam logic [1:0] NEG_REF = 2'h3;
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef struct packed {
    logic on;
    logic oe;
    logic inv;
    logic [1:0] edge_sel;
    logic ni_sel;
    logic [1:0] neg_sel;
  } tcc_cfg_t;
endpackage : tcc_pkg

//--- logic/tcc_sync.sv
// two-stage synchroniser for one asynchronous comparator level
`timescale 1ns/1ps
`default_nettype none
module tcc_sync (
  input wire logic clock,
  input wire logic reset,
  input wire logic async_in,
  output logic sync_out
);
  import tcc_pkg::*;
  typedef struct packed {
    logic s1;
    logic s2;
  } tcc_sync_t;
  tcc_sync_t st_ff;
  tcc_sync_t nxt_st;
  always_comb begin
    nxt_st.s1 = async_in;
    nxt_st.s2 = st_ff.s1;
  end
  always_ff @(posedge clock) begin
    if (reset) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign sync_out = st_ff.s2;
endmodule // tcc_sync
`default_nettype wire

//--- logic/tcc_top.sv
// three comparator control and status with reference control, AXI4-Lite
// Functional notes
// R1: a comparator works only while its enable bit is set.
// R2: with pin output enable set the result drives the pin, else stays inside.
// R3: output invert flips the result seen by status and events.
// R4: the event latch sets on the chosen event, blocks more, software clears.
// R5: edge select picks any, falling, rising or no event generation.
// R6: non-inverting select picks the reference level or input pin A.
// R7: inverting select picks pin B, C, D or the internal reference.
// R8: idle stop halts all comparators while the device is idle.
// R9: status bits 10..8 mirror the three event latches.
// R10: status bits 2..0 mirror the three results.
// R11: the pin value is the raw comparator output, not synchronised.
// R12: the 5-bit level code picks one of 32 reference levels.
// R13: bit 5 of reference control chooses the reference supply.
// R14: each comparator requests an interrupt when its latch rises.
`timescale 1ns/1ps
`default_nettype none
module tcc_top (
  input wire logic clock,
  input wire logic reset,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic device_idle,
  input wire logic [2:0] analog_result,
  output logic [2:0] comparator_output_pin_o,
  output logic [2:0] comparator_output_pin_oe,
  output logic [2:0] analog_enable,
  output logic [2:0] pos_input_select,
  output logic [5:0] neg_input_select,
  output logic [4:0] reference_level_code,
  output logic reference_supply_select,
  output logic [2:0] interrupt_request
);
  import tcc_pkg::*;

  typedef struct packed {
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [2:0][15:0] ctrl;
    logic idle_stop_all;
    logic [15:0] refctl;
    logic [2:0] run;
    logic idle_sync1;
    logic idle_sync2;
    logic [2:0] pin_oe;
    logic [2:0] irq;
  } tcc_state_t;

  tcc_state_t st_ff;
  tcc_state_t nxt_st;
  tcc_cfg_t [2:0] cfg;
  logic [2:0] raw_sync;
  logic [2:0] result;
  logic [2:0] evt;
  logic [2:0] irq_pulse;
  logic [2:0] evt_clear;
  logic do_write;
  logic [15:0] wr_val;
  logic wr_ok;
  logic [15:0] rd_val;
  logic rd_ok;
  logic [15:0] status_val;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_cmp
      assign cfg[gi].on = st_ff.ctrl[gi][POS_ON];
      assign cfg[gi].oe = st_ff.ctrl[gi][POS_OE];
      assign cfg[gi].inv = st_ff.ctrl[gi][POS_INV];
      assign cfg[gi].edge_sel = st_ff.ctrl[gi][POS_EDGE +: 2];
      assign cfg[gi].ni_sel = st_ff.ctrl[gi][POS_NISEL];
      assign cfg[gi].neg_sel = st_ff.ctrl[gi][POS_ISEL +: 2];
      tcc_sync u_sync (
        .clock(clock),
        .reset(reset),
        .async_in(analog_result[gi]),
        .sync_out(raw_sync[gi])
      );
      tcc_channel u_chan (
        .clock(clock),
        .reset(reset),
        .cfg(cfg[gi]),
        .run(st_ff.run[gi]),
        .raw_sync(raw_sync[gi]),
        .evt_clear(evt_clear[gi]),
        .result(result[gi]),
        .event_latch(evt[gi]),
        .irq_pulse(irq_pulse[gi])
      );
    end
  endgenerate

  // R9: event copies
  // R10: result copies
  assign status_val = {st_ff.idle_stop_all, 4'h0, evt, 5'h00, result};
  assign do_write = st_ff.aw_held & st_ff.w_held & ~st_ff.bvalid;

  always_comb begin
    wr_val = st_ff.w_data[15:0];
    wr_ok = 1'b1;
    evt_clear = 3'h0;
    case (st_ff.aw_addr)
      ADDR_CTRL0: evt_clear[0] = do_write & st_ff.w_strb[1] &
        ~wr_val[POS_EVT];
      ADDR_CTRL1: evt_clear[1] = do_write & st_ff.w_strb[1] &
        ~wr_val[POS_EVT];
      ADDR_CTRL2: evt_clear[2] = do_write & st_ff.w_strb[1] &
        ~wr_val[POS_EVT];
      ADDR_STATUS: wr_ok = 1'b1;
      ADDR_REFCTL: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  always_comb begin
    rd_ok = 1'b1;
    case (s_axi_araddr)
      ADDR_CTRL0: rd_val = {st_ff.ctrl[0][15:10], evt[0], result[0],
        st_ff.ctrl[0][7:0]};
      ADDR_CTRL1: rd_val = {st_ff.ctrl[1][15:10], evt[1], result[1],
        st_ff.ctrl[1][7:0]};
      ADDR_CTRL2: rd_val = {st_ff.ctrl[2][15:10], evt[2], result[2],
        st_ff.ctrl[2][7:0]};
      ADDR_STATUS: rd_val = status_val;
      ADDR_REFCTL: rd_val = st_ff.refctl;
      default: begin
        rd_val = 16'h0000;
        rd_ok = 1'b0;
      end
    endcase
  end

  always_comb begin
    nxt_st = st_ff;
    // write address and data captured in either order
    if (s_axi_awvalid & ~st_ff.aw_held) begin
      nxt_st.aw_held = 1'b1;
      nxt_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid & ~st_ff.w_held) begin
      nxt_st.w_held = 1'b1;
      nxt_st.w_data = s_axi_wdata;
      nxt_st.w_strb = s_axi_wstrb;
    end
    if (do_write) begin
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
      for (int i = 0; i < 3; i++) begin
        if (st_ff.aw_addr == ADDR_CTRL0 + 8'(4 * i)) begin
          if (st_ff.w_strb[0]) begin
            nxt_st.ctrl[i][7:0] = wr_val[7:0] & CTRL_WMASK[7:0];
          end
          if (st_ff.w_strb[1]) begin
            nxt_st.ctrl[i][15:8] = wr_val[15:8] & CTRL_WMASK[15:8];
          end
        end
      end
      if (st_ff.aw_addr == ADDR_STATUS && st_ff.w_strb[1]) begin
        nxt_st.idle_stop_all = wr_val[POS_IDLE_STOP];
      end
      if (st_ff.aw_addr == ADDR_REFCTL) begin
        if (st_ff.w_strb[0]) begin
          nxt_st.refctl[7:0] = wr_val[7:0] & REF_WMASK[7:0];
        end
        if (st_ff.w_strb[1]) begin
          nxt_st.refctl[15:8] = wr_val[15:8] & REF_WMASK[15:8];
        end
      end
    end
    if (st_ff.bvalid & s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
      nxt_st.aw_held = 1'b0;
      nxt_st.w_held = 1'b0;
    end
    if (s_axi_arvalid & ~st_ff.rvalid) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata = {16'h0000, rd_val};
      nxt_st.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (st_ff.rvalid & s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end
    nxt_st.idle_sync1 = device_idle;
    nxt_st.idle_sync2 = st_ff.idle_sync1;
    for (int i = 0; i < 3; i++) begin
      // R1: enable gate
      // R8: idle stop applies to all
      nxt_st.run[i] = cfg[i].on & ~(st_ff.idle_stop_all & st_ff.idle_sync2);
      // R2: pin drive enable
      // R11: pin takes raw unsynchronised result
      // drive enable follows run on the same edge, never outlives it
      nxt_st.pin_oe[i] = cfg[i].oe & nxt_st.run[i];
    end
    // R14: request pulse per latch rise
    nxt_st.irq = irq_pulse;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign s_axi_awready = ~st_ff.aw_held;
  assign s_axi_wready = ~st_ff.w_held;
  assign s_axi_bvalid = st_ff.bvalid;
  assign s_axi_bresp = st_ff.bresp;
  assign s_axi_arready = ~st_ff.rvalid;
  assign s_axi_rvalid = st_ff.rvalid;
  assign s_axi_rdata = st_ff.rdata;
  assign s_axi_rresp = st_ff.rresp;
  // R11: direct analog path, inverted by polarity, gated by enable
  assign comparator_output_pin_o = (analog_result ^ {cfg[2].inv, cfg[1].inv,
    cfg[0].inv}) & st_ff.pin_oe;
  assign comparator_output_pin_oe = st_ff.pin_oe;
  assign analog_enable = st_ff.run;
  // R6: non-inverting source
  assign pos_input_select = {cfg[2].ni_sel, cfg[1].ni_sel, cfg[0].ni_sel};
  // R7: inverting source
  assign neg_input_select = {cfg[2].neg_sel, cfg[1].neg_sel, cfg[0].neg_sel};
  // R12: level code
  assign reference_level_code = st_ff.refctl[POS_LEVEL +: 5];
  // R13: supply choice
  assign reference_supply_select = st_ff.refctl[POS_SUPPLY];
  assign interrupt_request = st_ff.irq;
endmodule // tcc_top
`default_nettype wire

//--- tb/tb_top.sv
// self-checking bench for the comparator block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import tcc_pkg::*;
  logic clock = 0, reset = 1, device_idle = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, seed = 29;
  logic [3:0] s_axi_wstrb = 4'h3;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, reference_supply_select;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [2:0] analog_result = 0, comparator_output_pin_o;
  logic [2:0] comparator_output_pin_oe, analog_enable, pos_input_select;
  logic [2:0] interrupt_request;
  logic [5:0] neg_input_select;
  logic [4:0] reference_level_code;
  int mismatches, n_checks, n_irq[3];
  tcc_top u_tcc_top (.*);
  always #20 clock = ~clock;
  always @(posedge clock) foreach (n_irq[i]) n_irq[i] += interrupt_request[i];
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // event expected for a result edge in the given direction
  function automatic logic ev(logic [1:0] e, logic up);
    return e == EDGE_ANY || (e == EDGE_RISE && up) || (e == EDGE_FALL && !up);
  endfunction
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'h3 | 4'(rnd() << 2);
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (1) begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 0;
        break;
      end
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    while (1) begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 0;
        break;
      end
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #(40 * 50000);
    mismatches++;
    results();
  end
  initial begin
    logic [31:0] d, c;
    logic [1:0] r, e, ng;
    logic inv, oe, ni, a;
    logic [7:0] ad;
    int b;
    repeat (8) @(posedge clock);
    reset <= 0;
    for (int k = 0; k < 5; k++) begin
      rd(8'(4 * k), d, r);
      chk(d, 32'h0);
    end
    rd(8'h20, d, r);
    chk(d, 32'h0);
    chk(r, RESP_SLVERR);
    wr(8'h20, rnd(), r);
    chk(r, RESP_SLVERR);
    repeat (4) begin
      c = rnd();
      wr(ADDR_REFCTL, c, r);
      rd(ADDR_REFCTL, d, r);
      chk(d, {16'h0, c[15:0] & REF_WMASK});
      chk(reference_level_code, c[4:0]);
      chk(reference_supply_select, c[5]);
    end
    $display("test registers done");
    for (int i = 0; i < 3; i++) for (int k = 0; k < 4; k++) begin
      d = rnd();
      e = 2'(k);
      {ng, ni, oe, inv} = d[4:0];
      // corner cases: pin driven with both polarities
      if (k == 0) {oe, inv} = 2'b10;
      if (k == 3) {oe, inv} = 2'b11;
      ad = 8'(4 * i);
      c = {16'h0, 1'b1, oe, inv, 5'h0, e, 1'b0, ni, 2'h0, ng};
      wr(ad, c, r);
      cyc(5);
      wr(ad, c, r);
      cyc(5);
      chk(pos_input_select[i], ni);
      chk(neg_input_select[2*i+:2], ng);
      chk(analog_enable[i], 1'b1);
      chk(comparator_output_pin_oe[i], oe);
      chk(comparator_output_pin_o[i], oe & inv);
      b = n_irq[i];
      analog_result[i] <= 1;
      cyc(1);
      chk(comparator_output_pin_o[i], oe & !inv);
      cyc(5);
      a = ev(e, !inv);
      rd(ADDR_STATUS, d, r);
      chk(d[8+i], a);
      chk(d[i], !inv);
      rd(ad, d, r);
      chk(d[9:8], {a, !inv});
      chk(32'(n_irq[i] - b), a);
      analog_result[i] <= 0;
      cyc(6);
      a = a | ev(e, inv);
      rd(ADDR_STATUS, d, r);
      chk(d[8+i], a);
      chk(32'(n_irq[i] - b), a);
      wr(ad, c, r);
      rd(ADDR_STATUS, d, r);
      chk(d[8+i], 1'b0);
    end
    $display("test comparators done");
    wr(ADDR_CTRL0, 32'h0, r);
    analog_result <= 3'h7;
    cyc(6);
    rd(ADDR_STATUS, d, r);
    chk(d[0], 1'b0);
    chk(analog_enable[0], 1'b0);
    wr(ADDR_STATUS, 32'h8000, r);
    device_idle <= 1;
    cyc(6);
    chk(analog_enable, 3'h0);
    wr(ADDR_STATUS, 32'h0, r);
    cyc(6);
    chk(analog_enable, 3'h6);
    device_idle <= 0;
    $display("test idle done");
    results();
  end
endmodule // tb_top
`default_nettype wire

//--- tb/tcc_top_sva.sv
// assertion checker for the comparator block ports
`timescale 1ns/1ps
`default_nettype none
module tcc_top_chk (
  input wire logic clock,
  input wire logic reset,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [2:0] analog_result,
  input wire logic [2:0] comparator_output_pin_o,
  input wire logic [2:0] comparator_output_pin_oe,
  input wire logic [2:0] analog_enable,
  input wire logic [2:0] pos_input_select,
  input wire logic [5:0] neg_input_select,
  input wire logic [4:0] reference_level_code,
  input wire logic reference_supply_select,
  input wire logic [2:0] interrupt_request
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  chk_pin_gated: assert property (
    (comparator_output_pin_o & ~comparator_output_pin_oe) == 3'h0)
    else $error("pin driven while its output is off");
  chk_oe_running: assert property (
    (comparator_output_pin_oe & ~analog_enable) == 3'h0)
    else $error("pin enabled on a stopped comparator");
  chk_pin_direct: assert property (
    comparator_output_pin_oe[0] && $stable(comparator_output_pin_oe[0])
    && $changed(analog_result[0]) |-> $changed(comparator_output_pin_o[0]))
    else $error("pin does not follow raw result at once");
  chk_irq_single: assert property (
    (interrupt_request & $past(interrupt_request)) == 3'h0)
    else $error("interrupt request longer than one cycle");
  chk_sel_by_write: assert property (
    $changed({pos_input_select, neg_input_select, reference_level_code,
    reference_supply_select}) |-> s_axi_bvalid || $past(s_axi_bvalid))
    else $error("selection changed without a write");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  chk_read_lat: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid)
    else $error("read answer late");
  chk_write_lat: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
endmodule // tcc_top_chk
bind tcc_top tcc_top_chk u_chk (.*);
`default_nettype wire
